//--- crieg_pkg.sv
// Shared constants for the companion reset, secondary I2C target and event glue.
// Assumes a single 250 MHz clock for both ends.
package crieg_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int RELEASE_HOLD_US = 100;
  localparam int RELEASE_HOLD_CYC = RELEASE_HOLD_US * CLK_MHZ;
  localparam int SCL_QTR_CYC = 250;

  // ----------------------------------------------------------------
  // Secondary I2C target
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_PORT_A = 7'h38;
  localparam logic [6:0] ADDR_PORT_B = 7'h3F;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [4:0] XFER_LAST = 5'h11;
  localparam int ACK_POS = 9;
  localparam int DATA_LSB = 1;

  // ----------------------------------------------------------------
  // Companion register map
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS_A = 5'h04;
  localparam logic [4:0] REG_STATUS_B = 5'h08;
  localparam logic [4:0] REG_EVENT = 5'h0C;
  localparam logic [4:0] REG_MASK = 5'h10;
  localparam logic [4:0] REG_STATE = 5'h14;
  localparam int CTRL_POLL_EN = 0;
  localparam int EVT_READ_A = 0;
  localparam int EVT_READ_B = 1;
  localparam int EVT_NACK = 2;
  localparam logic [2:0] EVT_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    T_IDLE = 5'b00001,
    T_ADDR = 5'b00010,
    T_AACK = 5'b00100,
    T_DATA = 5'b01000,
    T_MACK = 5'b10000
  } crieg_tgt_e;

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_START = 4'b0010,
    M_BIT = 4'b0100,
    M_STOP = 4'b1000
  } crieg_mst_e;

endpackage

//--- crieg_if.sv
// Link between the PD controller end and the companion end.
// Open-drain I2C levels are resolved here from the output enables.
`timescale 1ns/100ps
`default_nettype none
interface crieg_if;
  logic companion_reset_low;
  logic target_irq_low;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic tgt_sda_o;
  logic tgt_sda_oe;
  logic scl;
  logic sda;

  // ----------------------------------------------------------------
  // Wired-AND bus levels
  // ----------------------------------------------------------------
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (tgt_sda_oe & ~tgt_sda_o));

  modport dev_mp (
    output companion_reset_low,
    output target_irq_low,
    output tgt_sda_o,
    output tgt_sda_oe,
    input scl,
    input sda
  );

  modport cmp_mp (
    input companion_reset_low,
    input target_irq_low,
    input scl,
    input sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface
`default_nettype wire

//--- crieg_dev_end.sv
// PD controller end: companion reset hold-off, secondary I2C target,
// shared interrupt, sideband mux events and sink path control.
// Assumes PD logic inputs share i_clk; comparator and boot inputs are pins.
`timescale 1ns/100ps
`default_nettype none
module crieg_dev_end #(
  parameter int STATUS_BITS = 8
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cfg_done,
  input wire logic i_boot_gate_mode,
  input wire logic i_boot_ok,
  input wire logic [1:0] i_attach,
  input wire logic [STATUS_BITS-1:0] i_status_a,
  input wire logic [STATUS_BITS-1:0] i_status_b,
  input wire logic i_orient0,
  input wire logic i_dp_mode0,
  input wire logic i_ls_mode0,
  input wire logic [1:0] i_contract,
  input wire logic [1:0] i_ov,
  input wire logic [1:0] i_uv,
  output logic o_sink_path_en_port1,
  output logic o_sink_path_en_port2,
  output logic [1:0] o_vbus_source_en,
  output logic o_aux_pair_select,
  output logic o_lowspeed_pair_select,
  output logic o_aux_path_enable,
  output logic o_lowspeed_path_enable,
  crieg_if.dev_mp bus
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (STATUS_BITS != 8) begin : g_bad_width
    $error("STATUS_BITS must be 8");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] boot_sync;
  logic [1:0] ov_sync0;
  logic [1:0] ov_sync1;
  logic [1:0] uv_sync0;
  logic [1:0] uv_sync1;
  logic scl_d;
  logic sda_d;

  always_ff @(posedge i_clk) begin
    scl_sync <= {scl_sync[0], bus.scl};
    sda_sync <= {sda_sync[0], bus.sda};
    boot_sync <= {boot_sync[0], i_boot_ok};
    ov_sync0 <= i_ov;
    ov_sync1 <= ov_sync0;
    uv_sync0 <= i_uv;
    uv_sync1 <= uv_sync0;
    scl_d <= scl_sync[1];
    sda_d <= sda_sync[1];
  end

  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // Companion reset
  // ----------------------------------------------------------------
  // The companion fetches firmware only once this releases, after our own load
  wire boot_clear = ~i_boot_gate_mode | boot_sync[1];
  wire next_release = bus.companion_reset_low | (i_cfg_done & boot_clear);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      bus.companion_reset_low <= 1'b0;
    end else begin
      bus.companion_reset_low <= next_release;
    end
  end

  // ----------------------------------------------------------------
  // Secondary I2C target
  // ----------------------------------------------------------------
  crieg_pkg::crieg_tgt_e st;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic sel_b;
  logic mack;

  wire hit_a = shreg[7:1] == crieg_pkg::ADDR_PORT_A;
  wire hit_b = shreg[7:1] == crieg_pkg::ADDR_PORT_B;
  wire addr_ok = shreg[0] & (hit_a | hit_b);
  wire [7:0] load_byte = sel_b ? i_status_b : i_status_a;
  wire byte_done = (st == crieg_pkg::T_DATA) & scl_fall & (cnt == crieg_pkg::BYTE_BITS);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st <= crieg_pkg::T_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      sel_b <= 1'b0;
      mack <= 1'b0;
      bus.tgt_sda_oe <= 1'b0;
    end else if (stop_det) begin
      st <= crieg_pkg::T_IDLE;
      bus.tgt_sda_oe <= 1'b0;
    end else if (start_det) begin
      st <= crieg_pkg::T_ADDR;
      cnt <= 4'h0;
      bus.tgt_sda_oe <= 1'b0;
    end else begin
      unique case (st)
        crieg_pkg::T_IDLE: begin
        end
        crieg_pkg::T_ADDR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end else if (scl_fall && cnt == crieg_pkg::BYTE_BITS) begin
            if (addr_ok) begin
              st <= crieg_pkg::T_AACK;
              sel_b <= hit_b;
              bus.tgt_sda_oe <= 1'b1;
            end else begin
              st <= crieg_pkg::T_IDLE;
            end
          end
        end
        crieg_pkg::T_AACK: begin
          if (scl_fall) begin
            st <= crieg_pkg::T_DATA;
            tx <= load_byte;
            bus.tgt_sda_oe <= ~load_byte[7];
            cnt <= 4'h0;
          end
        end
        crieg_pkg::T_DATA: begin
          if (scl_rise) begin
            cnt <= cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == crieg_pkg::BYTE_BITS) begin
              st <= crieg_pkg::T_MACK;
              bus.tgt_sda_oe <= 1'b0;
            end else begin
              tx <= {tx[6:0], 1'b0};
              bus.tgt_sda_oe <= ~tx[6];
            end
          end
        end
        crieg_pkg::T_MACK: begin
          if (scl_rise) begin
            mack <= ~sda_s;
          end else if (scl_fall) begin
            if (mack) begin
              st <= crieg_pkg::T_DATA;
              tx <= load_byte;
              bus.tgt_sda_oe <= ~load_byte[7];
              cnt <= 4'h0;
            end else begin
              st <= crieg_pkg::T_IDLE;
            end
          end
        end
        default: begin
          st <= crieg_pkg::T_IDLE;
          bus.tgt_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shared interrupt
  // ----------------------------------------------------------------
  logic [1:0] attach_d;
  logic [1:0] pending;

  wire [1:0] attach_rise = i_attach & ~attach_d;
  wire [1:0] read_clr = byte_done ? {sel_b, ~sel_b} : 2'b00;
  wire [1:0] next_pending = (pending & ~read_clr) | attach_rise;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      attach_d <= 2'b00;
      pending <= 2'b00;
      bus.target_irq_low <= 1'b1;
      bus.tgt_sda_o <= 1'b0;
    end else begin
      attach_d <= i_attach;
      pending <= next_pending;
      bus.target_irq_low <= ~(|pending);
      bus.tgt_sda_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sideband mux events and power paths
  // ----------------------------------------------------------------
  wire [1:0] sink_ok = i_contract & ~ov_sync1 & ~uv_sync1;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_aux_pair_select <= 1'b0;
      o_lowspeed_pair_select <= 1'b0;
      o_aux_path_enable <= 1'b0;
      o_lowspeed_path_enable <= 1'b0;
      o_sink_path_en_port1 <= 1'b0;
      o_sink_path_en_port2 <= 1'b0;
      o_vbus_source_en <= 2'b00;
    end else begin
      o_aux_pair_select <= i_orient0;
      o_lowspeed_pair_select <= i_orient0;
      o_aux_path_enable <= i_dp_mode0;
      o_lowspeed_path_enable <= i_ls_mode0;
      o_sink_path_en_port1 <= sink_ok[0];
      o_sink_path_en_port2 <= sink_ok[1];
      o_vbus_source_en <= i_attach & ~i_contract;
    end
  end

endmodule
`default_nettype wire

//--- crieg_cmp_end.sv
// Companion end: gated reset release and I2C host that polls both ports.
// Assumes the PD controller end on the same clock; supply good is a pin.
`timescale 1ns/100ps
`default_nettype none
module crieg_cmp_end #(
  parameter int HOLD_CYC = crieg_pkg::RELEASE_HOLD_CYC,
  parameter int SCL_QTR = crieg_pkg::SCL_QTR_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_companion_supply_3v3,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_irq,
  output logic o_companion_run,
  crieg_if.cmp_mp bus
);

  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int QW = $clog2(SCL_QTR);

  if (HOLD_CYC < 1 || SCL_QTR < 8) begin : g_bad_param
    $error("HOLD_CYC must be at least 1 and SCL_QTR at least 8");
  end

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sup_sync;
  logic [1:0] sda_sync;

  always_ff @(posedge i_clk) begin
    sup_sync <= {sup_sync[0], i_companion_supply_3v3};
    sda_sync <= {sda_sync[0], bus.sda};
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [HW-1:0] hold_cnt;
  wire hold_done = hold_cnt == HW'(HOLD_CYC);
  wire next_run = sup_sync[1] & hold_done & bus.companion_reset_low;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !sup_sync[1]) begin
      hold_cnt <= '0;
    end else if (!hold_done) begin
      hold_cnt <= hold_cnt + HW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_companion_run <= 1'b0;
    end else begin
      o_companion_run <= next_run;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic poll_en;
  logic [2:0] mask;
  logic [2:0] evt;
  logic [7:0] stat_a;
  logic [7:0] stat_b;
  logic [2:0] evt_set;

  wire wr_ctrl = i_wr & (i_addr == crieg_pkg::REG_CTRL);
  wire wr_mask = i_wr & (i_addr == crieg_pkg::REG_MASK);
  wire rd_evt = i_rd & (i_addr == crieg_pkg::REG_EVENT);
  wire [2:0] next_evt = (evt & ~(rd_evt ? 3'h7 : 3'h0)) | evt_set;
  wire [7:0] rd_mux =
    (i_addr == crieg_pkg::REG_CTRL) ? {7'h00, poll_en} :
    (i_addr == crieg_pkg::REG_STATUS_A) ? stat_a :
    (i_addr == crieg_pkg::REG_STATUS_B) ? stat_b :
    (i_addr == crieg_pkg::REG_EVENT) ? {5'h00, evt} :
    (i_addr == crieg_pkg::REG_MASK) ? {5'h00, mask} :
    (i_addr == crieg_pkg::REG_STATE) ? {6'h00, ~bus.target_irq_low, o_companion_run} : 8'h00;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      poll_en <= 1'b0;
      mask <= crieg_pkg::MASK_RESET;
      evt <= crieg_pkg::EVT_RESET;
      o_rdata <= 8'h00;
      o_irq <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        poll_en <= i_wdata[crieg_pkg::CTRL_POLL_EN];
      end
      if (wr_mask) begin
        mask <= i_wdata[2:0];
      end
      evt <= next_evt;
      o_rdata <= i_rd ? rd_mux : 8'h00;
      o_irq <= |(evt & mask);
    end
  end

  // ----------------------------------------------------------------
  // I2C host
  // ----------------------------------------------------------------
  crieg_pkg::crieg_mst_e st;
  logic [QW-1:0] qcnt;
  logic [1:0] phase;
  logic [4:0] bits;
  logic [17:0] tx;
  logic [17:0] rx;
  logic port_b;

  wire tick = qcnt == QW'(SCL_QTR - 1);
  wire [17:0] frame_a = {crieg_pkg::ADDR_PORT_A, 1'b1, 10'h3FF};
  wire [17:0] frame_b = {crieg_pkg::ADDR_PORT_B, 1'b1, 10'h3FF};
  wire ack_ok = ~rx[crieg_pkg::ACK_POS];
  wire [7:0] rx_byte = rx[crieg_pkg::DATA_LSB +: 8];
  wire launch = o_companion_run & poll_en & ~bus.target_irq_low;
  wire frame_end = tick & (st == crieg_pkg::M_STOP) & (phase == 2'h2);

  assign evt_set[crieg_pkg::EVT_READ_A] = frame_end & ack_ok & ~port_b;
  assign evt_set[crieg_pkg::EVT_READ_B] = frame_end & ack_ok & port_b;
  assign evt_set[crieg_pkg::EVT_NACK] = frame_end & ~ack_ok;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || tick) begin
      qcnt <= '0;
    end else begin
      qcnt <= qcnt + QW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st <= crieg_pkg::M_IDLE;
      phase <= 2'h0;
      bits <= 5'h00;
      tx <= 18'h3FFFF;
      rx <= 18'h00000;
      port_b <= 1'b0;
      stat_a <= 8'h00;
      stat_b <= 8'h00;
      bus.host_scl_oe <= 1'b0;
      bus.host_sda_oe <= 1'b0;
      bus.host_scl_o <= 1'b0;
      bus.host_sda_o <= 1'b0;
    end else if (tick) begin
      phase <= phase + 2'h1;
      unique case (st)
        crieg_pkg::M_IDLE: begin
          phase <= 2'h0;
          if (launch) begin
            st <= crieg_pkg::M_START;
            port_b <= 1'b0;
            tx <= frame_a;
          end
        end
        crieg_pkg::M_START: begin
          if (phase == 2'h0) begin
            bus.host_sda_oe <= 1'b1;
          end else begin
            bus.host_scl_oe <= 1'b1;
            st <= crieg_pkg::M_BIT;
            phase <= 2'h0;
            bits <= 5'h00;
          end
        end
        crieg_pkg::M_BIT: begin
          unique case (phase)
            2'h0: bus.host_sda_oe <= ~tx[17];
            2'h1: bus.host_scl_oe <= 1'b0;
            2'h2: rx <= {rx[16:0], sda_sync[1]};
            2'h3: begin
              bus.host_scl_oe <= 1'b1;
              tx <= {tx[16:0], 1'b1};
              bits <= bits + 5'h01;
              if (bits == crieg_pkg::XFER_LAST) begin
                st <= crieg_pkg::M_STOP;
              end
            end
          endcase
        end
        crieg_pkg::M_STOP: begin
          unique case (phase)
            2'h0: bus.host_sda_oe <= 1'b1;
            2'h1: bus.host_scl_oe <= 1'b0;
            2'h2: begin
              bus.host_sda_oe <= 1'b0;
              phase <= 2'h0;
              if (ack_ok && !port_b) begin
                stat_a <= rx_byte;
              end
              if (ack_ok && port_b) begin
                stat_b <= rx_byte;
              end
              if (!port_b) begin
                st <= crieg_pkg::M_START;
                port_b <= 1'b1;
                tx <= frame_b;
              end else begin
                st <= crieg_pkg::M_IDLE;
              end
            end
            2'h3: phase <= 2'h0;
          endcase
        end
        default: begin
          st <= crieg_pkg::M_IDLE;
          bus.host_scl_oe <= 1'b0;
          bus.host_sda_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- crieg_props.sv
// Concurrent checks on the link between the two ends.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module crieg_props (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cfg_done,
  input wire logic i_boot_gate_mode,
  input wire logic i_boot_ok,
  input wire logic [1:0] i_attach,
  input wire logic companion_reset_low,
  input wire logic target_irq_low,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic tgt_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  // ----------------------------------------------------------------
  // Reset link
  // ----------------------------------------------------------------
  a_reset_cause: assert property ($rose(companion_reset_low) |-> $past(i_cfg_done))
    else $error("companion reset released before config load");
  a_reset_sticky: assert property (companion_reset_low |=> companion_reset_low)
    else $error("companion reset glitched back low");
  a_release_prompt: assert property (i_cfg_done && !i_boot_gate_mode |=> companion_reset_low)
    else $error("companion reset not released after config load");
  a_reset_low_start: assert property ($rose(i_reset_n) |-> !companion_reset_low)
    else $error("companion reset not low after own reset");
  a_gate_hold: assert property ($rose(companion_reset_low) && i_boot_gate_mode |-> $past(i_boot_ok, 2))
    else $error("companion reset released before boot reported");
  a_no_host_early: assert property (!companion_reset_low |-> !host_scl_oe)
    else $error("host clocked bus while held in reset");

  // ----------------------------------------------------------------
  // Interrupt and target
  // ----------------------------------------------------------------
  a_irq_on_attach: assert property ($rose(i_attach[0]) || $rose(i_attach[1]) |-> ##[1:3] !target_irq_low)
    else $error("no interrupt after connection");
  a_irq_release: assert property ($rose(target_irq_low) |-> !scl)
    else $error("interrupt released outside a data byte end");
  a_tgt_scl_low: assert property ($changed(tgt_sda_oe) |-> !scl)
    else $error("target moved data line while clock high");
  a_start_host: assert property ($fell(sda) && scl |-> host_sda_oe)
    else $error("start condition not made by host");

  c_release: cover property ($rose(companion_reset_low));
  c_irq_set: cover property ($fell(target_irq_low));
  c_irq_clear: cover property ($rose(target_irq_low));
  c_tgt_drive: cover property ($rose(tgt_sda_oe));
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench joining both ends through the link interface.
// Assumes shortened hold and bit-time parameters for a quick run.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int HOLD = 20;
  logic i_clk, i_reset_n, i_cfg_done, i_boot_gate_mode, i_boot_ok, i_orient0, i_dp_mode0, i_ls_mode0;
  logic [1:0] i_attach, i_contract, i_ov, i_uv, o_vbus_source_en, snk;
  logic [7:0] i_status_a, i_status_b, i_wdata, o_rdata;
  logic [4:0] i_addr;
  logic i_companion_supply_3v3, i_wr, i_rd, o_irq, o_companion_run;
  logic o_sink_path_en_port1, o_sink_path_en_port2, o_aux_pair_select;
  logic o_lowspeed_pair_select, o_aux_path_enable, o_lowspeed_path_enable;
  logic [31:0] seed = 32'h987D2023;
  int num_errors = 0;
  int compares = 0;
  int cnt;
  logic [7:0] model_q[$];

  crieg_if link ();
  crieg_dev_end crieg_dev_end_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cfg_done(i_cfg_done),
    .i_boot_gate_mode(i_boot_gate_mode), .i_boot_ok(i_boot_ok), .i_attach(i_attach),
    .i_status_a(i_status_a), .i_status_b(i_status_b), .i_orient0(i_orient0), .i_dp_mode0(i_dp_mode0),
    .i_ls_mode0(i_ls_mode0), .i_contract(i_contract), .i_ov(i_ov), .i_uv(i_uv),
    .o_sink_path_en_port1(o_sink_path_en_port1), .o_sink_path_en_port2(o_sink_path_en_port2),
    .o_vbus_source_en(o_vbus_source_en), .o_aux_pair_select(o_aux_pair_select),
    .o_lowspeed_pair_select(o_lowspeed_pair_select), .o_aux_path_enable(o_aux_path_enable),
    .o_lowspeed_path_enable(o_lowspeed_path_enable), .bus(link));
  crieg_cmp_end #(.HOLD_CYC(HOLD), .SCL_QTR(8)) crieg_cmp_end_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_companion_supply_3v3(i_companion_supply_3v3), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_companion_run(o_companion_run), .bus(link));
  crieg_props crieg_props_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cfg_done(i_cfg_done),
    .i_boot_gate_mode(i_boot_gate_mode), .i_boot_ok(i_boot_ok), .i_attach(i_attach),
    .companion_reset_low(link.companion_reset_low), .target_irq_low(link.target_irq_low),
    .host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe), .tgt_sda_oe(link.tgt_sda_oe),
    .scl(link.scl), .sda(link.sda));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic go(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 check(o_rdata, exp);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  initial begin
    go(20000);
    num_errors++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_reset_n, i_cfg_done, i_boot_ok, i_attach, i_orient0, i_dp_mode0, i_ls_mode0} = '0;
    {i_contract, i_ov, i_uv, i_status_a, i_status_b} = '0;
    {i_addr, i_wdata, i_wr, i_rd} = '0;
    i_boot_gate_mode = 1'b1;
    i_companion_supply_3v3 = 1'b1;
    go(8);
    i_reset_n <= 1'b1;
    rd(crieg_pkg::REG_CTRL, 8'h00);
    rd(crieg_pkg::REG_EVENT, 8'h00);
    rd(crieg_pkg::REG_MASK, 8'h00);
    go(30);
    #1 check({link.companion_reset_low, o_companion_run}, 16'h0000);
    @(posedge i_clk);
    i_cfg_done <= 1'b1;
    go(10);
    #1 check(link.companion_reset_low, 16'h0000);
    @(posedge i_clk);
    i_boot_ok <= 1'b1;
    go(6);
    #1 check(link.companion_reset_low, 16'h0001);
    go(3);
    #1 check(o_companion_run, 16'h0001);
    rd(crieg_pkg::REG_STATE, 8'h01);
    $display("test reset_release done");
    wr(crieg_pkg::REG_CTRL, 8'h01);
    wr(crieg_pkg::REG_MASK, 8'h07);
    for (int p = 0; p < 2; p++) begin
      seed = lfsr(seed);
      @(posedge i_clk);
      i_status_a <= seed[7:0];
      i_status_b <= seed[15:8];
      i_attach[p] <= 1'b1;
      model_q.delete();
      model_q.push_back(seed[7:0]);
      model_q.push_back(seed[15:8]);
      cnt = 0;
      while (link.target_irq_low !== 1'b0 && cnt < 8) begin
        @(posedge i_clk);
        #1 cnt++;
      end
      check(link.target_irq_low, 16'h0000);
      go(2000);
      #1 check({link.target_irq_low, o_irq}, {1'b1, p == 0});
      rd(crieg_pkg::REG_EVENT, 8'h03);
      rd(crieg_pkg::REG_STATUS_A, model_q[0]);
      rd(crieg_pkg::REG_STATUS_B, model_q[1]);
      check(o_irq, 16'h0000);
      wr(crieg_pkg::REG_MASK, 8'h00);
    end
    wr(crieg_pkg::REG_STATUS_A, 8'h5A);
    rd(crieg_pkg::REG_STATUS_A, model_q[0]);
    rd(5'h1C, 8'h00);
    $display("test interrupt_poll done");
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      @(posedge i_clk);
      {i_orient0, i_dp_mode0, i_ls_mode0, i_contract, i_ov, i_uv} <= seed[8:0];
      snk = seed[5:4] & ~seed[3:2] & ~seed[1:0];
      go(4);
      #1 check({o_sink_path_en_port2, o_sink_path_en_port1, o_vbus_source_en, o_aux_pair_select,
        o_lowspeed_pair_select, o_aux_path_enable, o_lowspeed_path_enable},
        {snk, ~seed[5:4], {2{seed[8]}}, seed[7:6]});
    end
    $display("test sideband_sink done");
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    i_companion_supply_3v3 <= 1'b0;
    i_boot_gate_mode <= 1'b0;
    i_attach <= 2'b00;
    go(8);
    i_reset_n <= 1'b1;
    #1 check(link.companion_reset_low, 16'h0000);
    @(posedge i_clk);
    #1 check(link.companion_reset_low, 16'h0001);
    go(30);
    #1 check(o_companion_run, 16'h0000);
    @(posedge i_clk);
    i_companion_supply_3v3 <= 1'b1;
    cnt = 0;
    while (o_companion_run !== 1'b1 && cnt < 40) begin
      @(posedge i_clk);
      #1 cnt++;
    end
    check(cnt >= HOLD && cnt <= HOLD + 4, 16'h0001);
    $display("test supply_gate done");
    complete_run();
  end
endmodule
`default_nettype wire
